// *** logic/pis_pkg.sv ***
// package: constants and carrier structs for the power-up init sequencer
package pis_pkg;

  // =====================================================================
  // timing and sizes
  // =====================================================================
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned OSC_STABLE_US  = 20;   // least oscillator settle time, us
  localparam int unsigned OSC_STABLE_CYC = OSC_STABLE_US * CLK_MHZ;
  localparam int unsigned CFG_WORDS      = 16;   // nonvolatile store depth
  localparam int unsigned CFG_WIDTH      = 16;   // nonvolatile word width
  localparam int unsigned ADC_BITS       = 10;   // strap converter resolution
  localparam int unsigned ADDR_BITS      = 7;
  localparam int unsigned OFFS_BITS      = 4;

  // strap code at or above this means the pin floats (analog mode)
  localparam logic [9:0] ADC_FLOAT_CODE  = 10'h3F0;
  // reset values of the base bus addresses
  localparam logic [6:0] I2C_BASE_RST    = 7'h10;
  localparam logic [6:0] PMB_BASE_RST    = 7'h40;
  // software enable options
  localparam logic [1:0] SWEN_DEFAULT    = 2'h0; // pin + uvlo + load + address
  localparam logic [1:0] SWEN_CMD_ONLY   = 2'h1; // software command only
  localparam logic [1:0] SWEN_CMD_AND_PIN = 2'h2; // command and pin

  // supply and oscillator monitor inputs
  typedef struct packed {
    logic bias_ok;        // main bias supply above threshold
    logic core_ok;        // core_supply_rail above threshold
    logic osc_ok;         // 48 MHz oscillator reports lock
  } pis_mon_t;

  // enable qualifiers sampled from analog comparators
  typedef struct packed {
    logic enable_pin_ok;  // enable_forced_ccm_pin above threshold
    logic vin_on_ok;      // input above default or programmed on threshold
    logic vin_off_ok;     // input above default or programmed off threshold
  } pis_qual_t;

  // bus host reconfiguration request
  typedef struct packed {
    logic       valid;
    logic       set_thr;      // select programmed vin on/off thresholds
    logic       thr_prog;
    logic       set_swen;
    logic [1:0] swen_mode;
    logic       sw_on;        // software operation command
  } pis_cmd_t;

  typedef enum logic [2:0] {
    ST_POR, ST_OSC_WAIT, ST_LOAD, ST_ADDR, ST_READY
  } pis_state_t;

endpackage

// *** logic/pis_adc_read.sv ***
// module: one-shot strap conversion with the internal 10-bit converter
`timescale 1ns/10ps
`default_nettype none
module pis_adc_read #(
  parameter int unsigned BITS = pis_pkg::ADC_BITS
) (
  input  wire logic            core_clk,
  input  wire logic            srst,
  input  wire logic            clk_en,
  input  wire logic            start,
  output logic                 adc_start,
  input  wire logic            adc_done,
  input  wire logic [BITS-1:0] adc_code,
  output logic                 done,
  output logic [BITS-1:0]      code_q
);
  import pis_pkg::*;

  // =====================================================================
  // conversion handshake
  // =====================================================================
  logic busy_q;

  // busy from start until the converter returns; done pulses one cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      busy_q <= 1'b0;
      done   <= 1'b0;
      code_q <= '0;
    end else if (clk_en) begin
      done <= 1'b0;
      if (start && !busy_q) begin
        busy_q <= 1'b1;
      end else if (busy_q && adc_done) begin
        busy_q <= 1'b0;
        done   <= 1'b1;
        code_q <= adc_code;
      end
    end
  end

  assign adc_start = busy_q;  // held high while waiting, converter sees a level
endmodule
`default_nettype wire

// *** logic/pis_sequencer.sv ***
// module: power-up reset, config load, address read and enable qualification
// Behaviour
// [R1] hold internal reset until bias, core supply ok and oscillator stable
// [R2] after reset copy every nonvolatile config word into working registers
// [R3] accept bus reconfiguration once loaded, whatever the enable pin does
// [R4] default enable needs pin, input uvlo, load complete and address read
// [R5] host-selected software enable options replace the default qualification
// [R6] derive address offset from strap voltage using 10-bit converter
// [R7] floating strap means analog mode: bus disabled, commands ignored
// [R8] programmed vin on/off thresholds replace the default 1 V lockout
// [R9] drop conversion enable at once when any qualifier is lost
`timescale 1ns/10ps
`default_nettype none
module pis_sequencer #(
  parameter int unsigned OSC_CYC = pis_pkg::OSC_STABLE_CYC,
  parameter int unsigned WORDS   = pis_pkg::CFG_WORDS,
  parameter int unsigned WIDTH   = pis_pkg::CFG_WIDTH
) (
  input  wire logic                             core_clk,
  input  wire logic                             srst,
  input  wire logic                             clk_en,
  input  wire pis_pkg::pis_mon_t                mon,
  input  wire pis_pkg::pis_qual_t               qual,
  input  wire pis_pkg::pis_qual_t               qual_prog,
  output logic [$clog2(WORDS)-1:0]              nv_addr,
  output logic                                  nv_rd,
  input  wire logic [WIDTH-1:0]                 nv_data,
  input  wire logic                             nv_valid,
  output logic                                  adc_start,
  input  wire logic                             adc_done,
  input  wire logic [pis_pkg::ADC_BITS-1:0]     adc_code,
  input  wire pis_pkg::pis_cmd_t                cmd,
  output logic                                  cmd_ready,
  output logic                                  por_n,
  output logic                                  load_done_q,
  output logic                                  addr_done_q,
  output logic                                  analog_mode_q,
  output logic [pis_pkg::ADDR_BITS-1:0]         i2c_addr_q,
  output logic [pis_pkg::ADDR_BITS-1:0]         pmb_addr_q,
  output logic [WIDTH-1:0]                      cfg_q [WORDS],
  output logic                                  conv_en_q
);
  import pis_pkg::*;

  localparam int unsigned AW = $clog2(WORDS);
  localparam int unsigned CW = $clog2(OSC_CYC + 1);

  // =====================================================================
  // state
  // =====================================================================
  pis_state_t      state_q;
  logic [CW-1:0]   osc_cnt_q;
  logic [AW-1:0]   ld_idx_q;
  logic            ld_wait_q;
  logic            adc_go;
  logic            adc_fin;
  logic [9:0]      adc_val;
  logic            mon_ok;
  logic            thr_prog_q;
  logic [1:0]      swen_q;
  logic            sw_on_q;
  logic            qual_all;

  assign mon_ok = mon.bias_ok && mon.core_ok && mon.osc_ok;

  // sequence: any monitor drop sends the part back to reset
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= ST_POR;
    end else if (clk_en) begin
      if (!mon_ok) begin
        state_q <= ST_POR; // see [R1]
      end else begin
        unique case (state_q)
          ST_POR:      state_q <= ST_OSC_WAIT;
          ST_OSC_WAIT: if (osc_cnt_q == CW'(OSC_CYC)) state_q <= ST_LOAD; // see [R1]
          ST_LOAD:     if (nv_rd && nv_valid && ld_idx_q == AW'(WORDS - 1)) state_q <= ST_ADDR;
          ST_ADDR:     if (adc_fin) state_q <= ST_READY;
          ST_READY:    state_q <= ST_READY;
        endcase
      end
    end
  end

  // oscillator settle counter; a glitch on the lock flag restarts it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      osc_cnt_q <= '0;
    end else if (clk_en) begin
      if (state_q != ST_OSC_WAIT) osc_cnt_q <= '0;
      else if (osc_cnt_q != CW'(OSC_CYC)) osc_cnt_q <= osc_cnt_q + 1'b1;
    end
  end

  assign por_n = (state_q != ST_POR) && (state_q != ST_OSC_WAIT); // see [R1]

  // =====================================================================
  // nonvolatile load: one word in flight at a time, simple but slow
  // =====================================================================
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ld_idx_q    <= '0;
      ld_wait_q   <= 1'b0;
      load_done_q <= 1'b0;
    end else if (clk_en) begin
      if (state_q != ST_LOAD) begin
        ld_idx_q  <= '0;
        ld_wait_q <= 1'b0;
        load_done_q <= (state_q == ST_ADDR || state_q == ST_READY) && load_done_q;
      end else if (!ld_wait_q) begin
        ld_wait_q <= 1'b1;
      end else if (nv_valid) begin
        ld_wait_q <= 1'b0;
        ld_idx_q  <= ld_idx_q + 1'b1;
        if (ld_idx_q == AW'(WORDS - 1)) load_done_q <= 1'b1; // see [R2]
      end
    end
  end

  assign nv_rd   = (state_q == ST_LOAD) && ld_wait_q;
  assign nv_addr = ld_idx_q;

  // working registers: loaded words, host writes do not touch this image
  generate
    for (genvar i = 0; i < WORDS; i++) begin : g_cfg
      always_ff @(posedge core_clk) begin
        if (srst) begin
          cfg_q[i] <= '0;
        end else if (clk_en && nv_rd && nv_valid && ld_idx_q == AW'(i)) begin
          cfg_q[i] <= nv_data; // see [R2]
        end
      end
    end
  endgenerate

  // =====================================================================
  // strap read and address
  // =====================================================================
  // no restart while the finished result is being taken, or a second conversion follows
  assign adc_go = (state_q == ST_ADDR) && !addr_done_q && !adc_fin;

  pis_adc_read #(
    .BITS (ADC_BITS)
  ) u_adc (
    .core_clk  (core_clk),
    .srst      (srst),
    .clk_en    (clk_en),
    .start     (adc_go),
    .adc_start (adc_start),
    .adc_done  (adc_done),
    .adc_code  (adc_code),
    .done      (adc_fin),
    .code_q    (adc_val)
  );

  // top four code bits give the offset; a near-full-scale code means floating
  always_ff @(posedge core_clk) begin
    if (srst || (clk_en && !mon_ok)) begin
      addr_done_q   <= 1'b0;
      analog_mode_q <= 1'b0;
      i2c_addr_q    <= I2C_BASE_RST;
      pmb_addr_q    <= PMB_BASE_RST;
    end else if (clk_en && adc_fin && state_q == ST_ADDR) begin
      addr_done_q   <= 1'b1;
      analog_mode_q <= (adc_val >= ADC_FLOAT_CODE); // see [R7]
      i2c_addr_q    <= I2C_BASE_RST + {3'h0, adc_val[9:6]}; // see [R6]
      pmb_addr_q    <= PMB_BASE_RST + {3'h0, adc_val[9:6]}; // see [R6]
    end
  end

  // =====================================================================
  // host reconfiguration
  // =====================================================================
  // taken only after load and outside analog mode, pin state irrelevant
  assign cmd_ready = load_done_q && addr_done_q && !analog_mode_q; // see [R3] [R7]

  always_ff @(posedge core_clk) begin
    if (srst || (clk_en && !mon_ok)) begin
      thr_prog_q <= 1'b0;
      swen_q     <= SWEN_DEFAULT;
      sw_on_q    <= 1'b0;
    end else if (clk_en && cmd.valid && cmd_ready) begin
      if (cmd.set_thr) thr_prog_q <= cmd.thr_prog; // see [R8]
      if (cmd.set_swen) swen_q <= cmd.swen_mode;  // see [R5]
      sw_on_q <= cmd.sw_on;
    end
  end

  // =====================================================================
  // enable qualification
  // =====================================================================
  pis_qual_t q_sel;
  logic      vin_ok;
  logic      vin_up_q;

  // the pin threshold is fixed; only the input thresholds are programmable
  assign q_sel.enable_pin_ok = qual.enable_pin_ok;
  assign q_sel.vin_on_ok     = thr_prog_q ? qual_prog.vin_on_ok : qual.vin_on_ok;   // see [R8]
  assign q_sel.vin_off_ok    = thr_prog_q ? qual_prog.vin_off_ok : qual.vin_off_ok; // see [R8]

  // input uvlo with hysteresis; a power-on reset forgets it, so the on level is met again
  always_ff @(posedge core_clk) begin
    if (srst || (clk_en && !mon_ok)) begin
      vin_up_q <= 1'b0; // see [R9]
    end else if (clk_en) begin
      if (q_sel.vin_on_ok) vin_up_q <= 1'b1;
      else if (!q_sel.vin_off_ok) vin_up_q <= 1'b0;
    end
  end
  assign vin_ok = vin_up_q && q_sel.vin_off_ok;

  always_comb begin
    qual_all = 1'b0;
    if (!(load_done_q && addr_done_q && vin_ok)) begin
      qual_all = 1'b0;
    end else if (analog_mode_q || swen_q == SWEN_DEFAULT) begin
      qual_all = q_sel.enable_pin_ok; // see [R4]
    end else if (swen_q == SWEN_CMD_ONLY) begin
      qual_all = sw_on_q; // see [R5]
    end else if (swen_q == SWEN_CMD_AND_PIN) begin
      qual_all = sw_on_q && q_sel.enable_pin_ok; // see [R5]
    end else begin
      qual_all = q_sel.enable_pin_ok;
    end
  end

  // registered on every clk_en cycle, so a lost qualifier drops it at the next enabled edge
  always_ff @(posedge core_clk) begin
    if (srst) begin
      conv_en_q <= 1'b0;
    end else if (clk_en) begin
      conv_en_q <= qual_all && mon_ok; // see [R9] [R4]
    end
  end

  // =====================================================================
  // checks
  // =====================================================================
  a_por_holds_reset: assert property (@(posedge core_clk) disable iff (srst) // see [R1]
    (clk_en && !mon_ok) |=> !por_n && !conv_en_q)
    else $error("reset not held with monitors low");
  a_load_before_addr: assert property (@(posedge core_clk) disable iff (srst) // see [R2]
    addr_done_q |-> load_done_q)
    else $error("address read before load done");
  a_cmd_after_load: assert property (@(posedge core_clk) disable iff (srst) // see [R3]
    cmd_ready |-> load_done_q && !analog_mode_q)
    else $error("commands taken too early");
  a_enable_default: assert property (@(posedge core_clk) disable iff (srst) // see [R4]
    (clk_en && mon_ok && load_done_q && addr_done_q && vin_ok && swen_q == SWEN_DEFAULT
     && q_sel.enable_pin_ok) |=> conv_en_q)
    else $error("default enable not granted");
  a_swen_cmd_only: assert property (@(posedge core_clk) disable iff (srst) // see [R5]
    (clk_en && !analog_mode_q && swen_q == SWEN_CMD_ONLY && !sw_on_q) |=> !conv_en_q)
    else $error("software off ignored");
  a_addr_offset: assert property (@(posedge core_clk) disable iff (srst) // see [R6]
    (clk_en && mon_ok && adc_fin && state_q == ST_ADDR)
    |=> pmb_addr_q == PMB_BASE_RST + {3'h0, $past(adc_val[9:6])})
    else $error("address offset wrong");
  a_analog_no_cmd: assert property (@(posedge core_clk) disable iff (srst) // see [R7]
    (clk_en && mon_ok && analog_mode_q && cmd.valid)
    |=> swen_q == $past(swen_q) && sw_on_q == $past(sw_on_q) && thr_prog_q == $past(thr_prog_q))
    else $error("bus active in analog mode");
  a_thr_select: assert property (@(posedge core_clk) disable iff (srst) // see [R8]
    (clk_en && thr_prog_q && !qual_prog.vin_off_ok) |=> !conv_en_q)
    else $error("programmed off threshold ignored");
  a_qual_loss_drop: assert property (@(posedge core_clk) disable iff (srst) // see [R9]
    (conv_en_q && clk_en && !q_sel.enable_pin_ok && swen_q != SWEN_CMD_ONLY) |=> !conv_en_q)
    else $error("enable kept after qualifier loss");

  c_reach_ready: cover property (@(posedge core_clk) disable iff (srst) state_q == ST_READY);
  c_conv_on:     cover property (@(posedge core_clk) disable iff (srst) $rose(conv_en_q));
  c_analog:      cover property (@(posedge core_clk) disable iff (srst) $rose(analog_mode_q));
  c_sw_enable:   cover property (@(posedge core_clk) disable iff (srst)
    conv_en_q && swen_q == SWEN_CMD_ONLY);
endmodule
`default_nettype wire

// *** test/pis_partner.sv ***
// partner model: nonvolatile store and strap converter facing the sequencer
`timescale 1ns/10ps
`default_nettype none
module pis_partner #(
  parameter int unsigned WORDS = 4
) (
  input  wire logic                     core_clk,
  input  wire logic                     slow,
  input  wire logic [9:0]               strap_code,
  input  wire logic [$clog2(WORDS)-1:0] nv_addr,
  input  wire logic                     nv_rd,
  output logic [15:0]                   nv_data,
  output logic                          nv_valid,
  input  wire logic                     adc_start,
  output logic                          adc_done,
  output logic [9:0]                    adc_code
);
  logic [2:0] wait_q;
  logic       conv_q;

  initial begin
    nv_data  = 16'h0000;
    nv_valid = 1'b0;
    wait_q   = 3'h0;
    adc_done = 1'b0;
    adc_code = 10'h000;
    conv_q   = 1'b0;
  end

  // =====================================================================
  // nonvolatile store
  // =====================================================================
  // word i reads back as 0x5a00 + i; a released bus shows the inverse, never the old word
  always @(posedge core_clk) begin
    if (nv_valid || !nv_rd) begin
      nv_valid <= 1'b0;
      wait_q   <= slow ? 3'h4 : 3'h0;
      if (nv_valid) begin
        nv_data <= ~nv_data;
      end
    end else if (wait_q != 3'h0) begin
      wait_q <= wait_q - 3'h1;
    end else begin
      nv_valid <= 1'b1;
      nv_data  <= 16'h5a00 + 16'(nv_addr);
    end
  end

  // =====================================================================
  // strap converter
  // =====================================================================
  // one done pulse per start level; the code is only valid with the pulse
  always @(posedge core_clk) begin
    adc_done <= 1'b0;
    adc_code <= ~strap_code;
    if (!adc_start) begin
      conv_q <= 1'b0;
    end else if (!conv_q) begin
      conv_q   <= 1'b1;
      adc_done <= 1'b1;
      adc_code <= strap_code;
    end
  end
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// testbench: power-up rows, then command, threshold and loss cases
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import pis_pkg::*;

  typedef struct {
    logic [9:0] code;
    logic [2:0] q;
    logic       analog;
    logic [6:0] offs;
    logic       conv;
  } pis_row_t;

  logic        core_clk;
  logic        srst;
  logic        clk_en;
  logic        slow;
  logic [9:0]  strap;
  pis_mon_t    mon;
  pis_qual_t   qual;
  pis_qual_t   qual_prog;
  pis_cmd_t    cmd;
  logic [1:0]  nv_addr;
  logic        nv_rd;
  logic [15:0] nv_data;
  logic        nv_valid;
  logic        adc_start;
  logic        adc_done;
  logic [9:0]  adc_code;
  logic        cmd_ready;
  logic        por_n;
  logic        load_done_q;
  logic        addr_done_q;
  logic        analog_mode_q;
  logic [6:0]  i2c_addr_q;
  logic [6:0]  pmb_addr_q;
  logic [15:0] cfg [4];
  logic        conv_en_q;
  int          num_errors;
  int          n_tests;

  // qual is {pin, vin_on, vin_off}; offsets come from code[9:6]
  pis_row_t rows [5] = '{
    '{10'h000, 3'b111, 1'b0, 7'h00, 1'b1},
    '{10'h140, 3'b101, 1'b0, 7'h05, 1'b0},
    '{10'h3c0, 3'b011, 1'b0, 7'h0f, 1'b0},
    '{10'h3ef, 3'b111, 1'b0, 7'h0f, 1'b1},
    '{10'h3f0, 3'b111, 1'b1, 7'h00, 1'b1}
  };

  pis_sequencer #(.OSC_CYC(10), .WORDS(4), .WIDTH(16)) u_pis_sequencer (
    .core_clk(core_clk), .srst(srst), .clk_en(clk_en), .mon(mon), .qual(qual),
    .qual_prog(qual_prog), .nv_addr(nv_addr), .nv_rd(nv_rd), .nv_data(nv_data),
    .nv_valid(nv_valid), .adc_start(adc_start), .adc_done(adc_done),
    .adc_code(adc_code), .cmd(cmd), .cmd_ready(cmd_ready), .por_n(por_n),
    .load_done_q(load_done_q), .addr_done_q(addr_done_q),
    .analog_mode_q(analog_mode_q), .i2c_addr_q(i2c_addr_q),
    .pmb_addr_q(pmb_addr_q), .cfg_q(cfg), .conv_en_q(conv_en_q));

  pis_partner #(.WORDS(4)) u_pis_partner (
    .core_clk(core_clk), .slow(slow), .strap_code(strap), .nv_addr(nv_addr),
    .nv_rd(nv_rd), .nv_data(nv_data), .nv_valid(nv_valid), .adc_start(adc_start),
    .adc_done(adc_done), .adc_code(adc_code));

  // =====================================================================
  // helpers
  // =====================================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // caller stands at a falling edge; last drops valid, else the next call follows on
  task automatic send_cmd(input logic [2:0] flags, input logic [1:0] mode,
                          input logic on, input logic last);
    cmd = {1'b1, flags, mode, on};
    ticks(1);
    if (last) begin
      cmd.valid = 1'b0;
    end
  endtask

  // monitors drop, oscillator stays unstable a while, then all good until address read
  task automatic power_up(input logic [9:0] code);
    int k;
    mon   = 3'b000;
    strap = code;
    ticks(2);
    check(por_n, 1'b0);
    mon = 3'b110;
    ticks(30);
    check(por_n, 1'b0);
    mon = 3'b111;
    ticks(5);
    check(por_n, 1'b0);
    k   = 0;
    while (addr_done_q !== 1'b1 && k < 400) begin
      if (conv_en_q !== 1'b0) check(conv_en_q, 1'b0);
      ticks(1);
      k++;
    end
    check(addr_done_q, 1'b1);
    check(load_done_q, 1'b1);
    check(por_n, 1'b1);
    for (int i = 0; i < 4; i++) check(cfg[i], 16'h5a00 + i);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // =====================================================================
  // clock, watchdog, sequence
  // =====================================================================
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // the run needs roughly 530 cycles; 10,000 cycles leaves a wide margin
  initial begin
    #40_000;
    num_errors++;
    give_verdict();
  end

  initial begin
    num_errors = 0;
    n_tests    = 0;
    srst = 1'b1;
    clk_en = 1'b1;
    slow = 1'b0;
    strap = 10'h000;
    mon = 3'b111;
    qual = 3'b000;
    qual_prog = 3'b000;
    cmd = 7'h00;
    ticks(12);
    check(por_n, 1'b0);
    check(conv_en_q, 1'b0);
    check(i2c_addr_q, I2C_BASE_RST);
    srst = 1'b0;
    // ordinary power-ups, the store alternately prompt and slow
    foreach (rows[i]) begin
      slow = i[0];
      qual = rows[i].q;
      power_up(rows[i].code);
      ticks(3);
      check(analog_mode_q, rows[i].analog);
      check(cmd_ready, !rows[i].analog);
      check(conv_en_q, rows[i].conv);
      if (!rows[i].analog) check(i2c_addr_q, I2C_BASE_RST + rows[i].offs);
      if (!rows[i].analog) check(pmb_addr_q, PMB_BASE_RST + rows[i].offs);
    end
    // analog mode ignores a software-only enable while the pin is low
    qual = 3'b011;
    send_cmd(3'b001, SWEN_CMD_ONLY, 1'b1, 1'b1);
    ticks(3);
    check(conv_en_q, 1'b0);
    // digital again: software options with the pin low
    power_up(10'h000);
    ticks(2);
    check(conv_en_q, 1'b0);
    send_cmd(3'b001, SWEN_CMD_ONLY, 1'b1, 1'b1);
    ticks(3);
    check(conv_en_q, 1'b1);
    send_cmd(3'b001, SWEN_CMD_AND_PIN, 1'b1, 1'b1);
    ticks(3);
    check(conv_en_q, 1'b0);
    qual = 3'b111;
    ticks(3);
    check(conv_en_q, 1'b1);
    // back-to-back: software off, then default again
    send_cmd(3'b001, SWEN_CMD_ONLY, 1'b0, 1'b0);
    send_cmd(3'b001, SWEN_DEFAULT, 1'b0, 1'b1);
    ticks(3);
    check(conv_en_q, 1'b1);
    // programmed thresholds take over from the 1 V default
    send_cmd(3'b110, SWEN_DEFAULT, 1'b0, 1'b1);
    ticks(3);
    check(conv_en_q, 1'b0);
    qual_prog = 3'b111;
    ticks(3);
    check(conv_en_q, 1'b1);
    // losing the pin drops conversion at once
    qual = 3'b011;
    ticks(2);
    check(conv_en_q, 1'b0);
    qual = 3'b111;
    ticks(3);
    check(conv_en_q, 1'b1);
    // clock enable low freezes the enable; it drops once the clock runs again
    clk_en = 1'b0;
    qual   = 3'b011;
    ticks(3);
    check(conv_en_q, 1'b1);
    clk_en = 1'b1;
    ticks(2);
    check(conv_en_q, 1'b0);
    qual = 3'b111;
    // core supply lost in mid-run: back to reset, conversion off
    mon = 3'b101;
    ticks(2);
    check(por_n, 1'b0);
    check(conv_en_q, 1'b0);
    // second reset in mid-run, then a fresh power-up and the spare option code
    srst = 1'b1;
    mon  = 3'b111;
    ticks(2);
    check(load_done_q, 1'b0);
    check(i2c_addr_q, I2C_BASE_RST);
    srst = 1'b0;
    power_up(10'h140);
    ticks(3);
    check(pmb_addr_q, PMB_BASE_RST + 7'h05);
    check(conv_en_q, 1'b1);
    send_cmd(3'b001, 2'h3, 1'b0, 1'b1);
    ticks(3);
    check(conv_en_q, 1'b1);
    qual = 3'b011;
    ticks(2);
    check(conv_en_q, 1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire
